// [ecg_lead_format_select.v]
`timescale 1ns/10ps
`default_nettype none
`include "lead_format_consts.vh"
module ecg_lead_format_select (
	input  wire        core_clk,
	input  wire        srst,
	input  wire        output_format_select,
	input  wire        input_config_select,
	input  wire        common_electrode_enable,
	input  wire [1:0]  data_rate,
	input  wire        sample_valid,
	input  wire [13:0] ch1_sample,
	input  wire [13:0] ch2_sample,
	input  wire [13:0] ch3_sample,
	output reg  [15:0] word1,
	output reg  [15:0] word2,
	output reg  [15:0] word3,
	output reg         word_valid,
	output reg  [4:0]  mode_onehot,
	output reg         mode_error,
	output reg         ch_diff_en,
	output reg         ch_ce_ref_en,
	output reg         cm_config_used
);
	localparam [4:0] M_ANALOG  = 5'h01;
	localparam [4:0] M_DIGITAL = 5'h02;
	localparam [4:0] M_CE_A    = 5'h04;
	localparam [4:0] M_SE_ELEC = 5'h08;
	localparam [4:0] M_CE_B    = 5'h10;
	localparam [4:0] M_NONE    = 5'h00;

	// remove the mid-scale reference so words are signed around zero
	function [15:0] deref;
		input [13:0] s;
		begin
			deref = {2'b00, s} - {2'b00, `REF_LEVEL};
		end
	endfunction

	// one-hot mode for a selection; digital lead needs a supported rate
	function [4:0] decode_mode;
		input fmt;
		input cfg;
		input ce;
		input rate_fits;
		begin
			// 011, 110, 111 and digital lead at a fast rate all fall to M_NONE
			case ({fmt, cfg, ce})
				3'b010: decode_mode = M_ANALOG;
				3'b000: decode_mode = rate_fits ? M_DIGITAL : M_NONE;
				3'b001: decode_mode = M_CE_A;
				3'b100: decode_mode = M_SE_ELEC;
				3'b101: decode_mode = M_CE_B;
				default: decode_mode = M_NONE; // unsupported combination
			endcase
		end
	endfunction

	// a mode that yields frame words; M_NONE covers every refused selection
	function mode_live;
		input [4:0] m;
		begin
			mode_live = (m != M_NONE);
		end
	endfunction

	reg  [4:0]  mode_next;
	reg         rate_ok;
	reg  [15:0] e1_reg;
	reg  [15:0] e2_reg;
	reg  [15:0] e3_reg;
	reg  [4:0]  mode_s_reg;
	reg         v1_reg;
	reg  [15:0] w1_next;
	reg  [15:0] w2_next;
	reg  [15:0] w3_next;
	wire [15:0] lead_i;
	wire [15:0] lead_ii;
	wire [15:0] lead_iii;
	wire [15:0] v1_prime;

	// decode of the three selection bits
	always @* begin
		rate_ok   = (data_rate == `RATE_2KHZ) || (data_rate == `RATE_16KHZ);
		mode_next = decode_mode(output_format_select, input_config_select,
			common_electrode_enable, rate_ok);
	end

	lead_arith u_i (
		.a_in       (e1_reg),
		.b_in       (e3_reg),
		.c_in       (e3_reg),
		.a_minus_b  (lead_i),
		.ce_a_third ()
	);
	lead_arith u_ii (
		.a_in       (e2_reg),
		.b_in       (e3_reg),
		.c_in       (e3_reg),
		.a_minus_b  (lead_ii),
		.ce_a_third ()
	);
	lead_arith u_iii (
		.a_in       (e2_reg),
		.b_in       (e1_reg),
		.c_in       (e3_reg),
		.a_minus_b  (lead_iii),
		.ce_a_third (v1_prime)
	);

	// stage two selects the words for the latched mode
	always @* begin
		w1_next = 16'h0000;
		w2_next = 16'h0000;
		w3_next = 16'h0000;
		case (mode_s_reg)
			M_ANALOG: begin
				// channels already hold leads; analog stage inverts lead II
				w1_next = e1_reg;
				w2_next = 16'h0000 - e2_reg;
				w3_next = e3_reg;
			end
			M_DIGITAL: begin
				// channels are LA, LL, RA against the internal average
				w1_next = lead_i;
				w2_next = lead_ii;
				w3_next = lead_iii;
			end
			M_CE_A: begin
				// ch1=LA-RA, ch2=LL-RA, ch3=V1-RA because RA is the common
				w1_next = e1_reg;
				w2_next = e2_reg;
				w3_next = v1_prime;
			end
			M_SE_ELEC: begin
				w1_next = e1_reg;
				w2_next = e2_reg;
				w3_next = e3_reg;
			end
			M_CE_B: begin
				// raw electrodes against ce; leads are left to the host
				w1_next = e1_reg;
				w2_next = e2_reg;
				w3_next = e3_reg;
			end
			default: begin
				w1_next = 16'h0000;
				w2_next = 16'h0000;
				w3_next = 16'h0000;
			end
		endcase
	end

	// sample stage: reference removed, mode latched together with the sample
	always @(posedge core_clk) begin
		if (srst) begin
			e1_reg     <= 16'h0000;
			e2_reg     <= 16'h0000;
			e3_reg     <= 16'h0000;
			mode_s_reg <= M_NONE;
			v1_reg     <= 1'b0;
		end else begin
			e1_reg     <= deref(ch1_sample);
			e2_reg     <= deref(ch2_sample);
			e3_reg     <= deref(ch3_sample);
			// latching the mode here keeps a frame whole if the selection moves
			// while the words are still in flight
			mode_s_reg <= mode_next;
			// unsupported combinations give no frame words, only the error flag
			v1_reg     <= sample_valid && mode_live(mode_next);
		end
	end

	// word stage: words follow the samples every cycle, valid marks the frame
	always @(posedge core_clk) begin
		if (srst) begin
			word1      <= 16'h0000;
			word2      <= 16'h0000;
			word3      <= 16'h0000;
			word_valid <= 1'b0;
		end else begin
			word1      <= w1_next;
			word2      <= w2_next;
			word3      <= w3_next;
			word_valid <= v1_reg;
		end
	end

	// status stage: one cycle behind the selection inputs
	always @(posedge core_clk) begin
		if (srst) begin
			mode_onehot    <= M_NONE;
			mode_error     <= 1'b0;
			ch_diff_en     <= 1'b0;
			ch_ce_ref_en   <= 1'b0;
			cm_config_used <= 1'b0;
		end else begin
			mode_onehot    <= mode_next;
			mode_error     <= !mode_live(mode_next);
			ch_diff_en     <= input_config_select;
			ch_ce_ref_en   <= common_electrode_enable && !input_config_select;
			// digital lead mode overrides the common-mode reference setting
			cm_config_used <= (mode_next != M_DIGITAL) && mode_live(mode_next);
		end
	end
endmodule // ecg_lead_format_select
`default_nettype wire

// [host_frame_sink.sv]
`timescale 1ns/10ps
`default_nettype none
// host counts frames; lead math from ce words stays on its side
module host_frame_sink (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        word_valid,
	input  wire logic [15:0] word1,
	input  wire logic [15:0] word2,
	output var  int          frames,
	output wire logic [15:0] derived_lead_iii
);
	always @(posedge core_clk) begin
		if (srst) frames <= 0;
		else if (word_valid) frames <= frames + 1;
	end
	// with ra as the common, ll word minus la word is lead iii
	assign derived_lead_iii = word2 - word1;
endmodule // host_frame_sink
`default_nettype wire

// [lead_arith.v]
`timescale 1ns/10ps
`default_nettype none
`include "lead_format_consts.vh"
// combinational difference and third-of-sum helpers, signed 16-bit words
module lead_arith (
	input  wire signed [15:0] a_in,
	input  wire signed [15:0] b_in,
	input  wire signed [15:0] c_in,
	output wire signed [15:0] a_minus_b,
	output wire signed [15:0] ce_a_third
);
	wire signed [17:0] sum3;
	wire signed [17:0] quot;
	assign a_minus_b  = a_in - b_in;
	// c - (a + b) / 3; only the sum is divided, toward zero, so its fraction is lost
	assign sum3       = {{2{a_in[15]}}, a_in} + {{2{b_in[15]}}, b_in};
	assign quot       = sum3 / 18'sd3;
	assign ce_a_third = c_in - quot[15:0];
endmodule // lead_arith
`default_nettype wire

// [lead_format_checker_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module lead_format_checker (
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       output_format_select,
	input wire logic       input_config_select,
	input wire logic       common_electrode_enable,
	input wire logic [1:0] data_rate,
	input wire logic       sample_valid,
	input wire logic       word_valid,
	input wire logic [4:0] mode_onehot,
	input wire logic       mode_error,
	input wire logic       cm_config_used
);
	wire [2:0] sel = {output_format_select, input_config_select, common_electrode_enable};
	wire       ok  = sel == 3'h2 || sel == 3'h1 || sel[2] && !sel[1] || sel == 3'h0 && !data_rate[1];
	default clocking @(posedge core_clk); endclocking
	// outputs still show reset on the first edge after release, so wait one
	logic armed_reg = 1'b0;
	always @(posedge core_clk) armed_reg <= !srst;
	default disable iff (srst || !armed_reg);
	sequence s_take; sample_valid && ok; endsequence
	chk_analog_mode: assert property (sel == 3'h2 |=> mode_onehot == 5'h01)
		else $error("analog mode flag wrong");
	chk_digital_mode: assert property (sel == 3'h0 && !data_rate[1] |=> mode_onehot == 5'h02)
		else $error("digital mode flag wrong");
	chk_ce_a_mode: assert property (sel == 3'h1 |=> mode_onehot == 5'h04)
		else $error("ce a flag wrong");
	chk_electrode_mode: assert property (sel == 3'h4 |=> mode_onehot == 5'h08)
		else $error("electrode flag wrong");
	chk_ce_b_mode: assert property (sel == 3'h5 |=> mode_onehot == 5'h10)
		else $error("ce b flag wrong");
	chk_rate_refused: assert property (sel == 3'h0 && data_rate[1] |=> mode_error)
		else $error("digital lead at high rate accepted");
	chk_cm_ignored: assert property (sel == 3'h0 |=> !cm_config_used)
		else $error("common-mode config used in digital lead");
	chk_word_latency: assert property (s_take |-> ##2 word_valid)
		else $error("words late or missing");
endmodule // lead_format_checker
bind ecg_lead_format_select lead_format_checker lead_format_checker_inst (.*);
`default_nettype wire

// [lead_format_consts.vh]
`ifndef LEAD_FORMAT_CONSTS_VH
`define LEAD_FORMAT_CONSTS_VH
// register offsets and bit positions of the selection bits
`define FRAME_CONTROL_REG_ADDR       8'h0A
`define OUTPUT_FORMAT_BIT            4
`define CHANNEL_CONTROL_REG_ADDR     8'h01
`define INPUT_CONFIG_BIT             10
`define COMMON_MODE_REF_REG_ADDR     8'h05
`define COMMON_ELECTRODE_BIT         8
// sample width and reference level (mid-scale of offset-binary adc code)
`define SAMPLE_W                     14
`define WORD_W                       16
`define REF_LEVEL                    14'h2000
// output data rate codes
`define RATE_2KHZ                    2'h0
`define RATE_16KHZ                   2'h1
`define RATE_128KHZ                  2'h2
`define RATE_31K25HZ                 2'h3
// pipeline depth from samples to frame words, in core_clk cycles (lead arithmetic itself is combinational)
`define LEAD_LATENCY                 2
`endif

// [test_ecg_lead_format_select.sv]
`timescale 1ns/10ps
`default_nettype none
module test_ecg_lead_format_select;
	logic core_clk = 0, srst = 1, sample_valid = 0;
	logic output_format_select = 0, input_config_select = 0, common_electrode_enable = 0;
	logic [1:0]  data_rate = 0;
	logic [13:0] ch1_sample = 0, ch2_sample = 0, ch3_sample = 0;
	wire  [15:0] word1, word2, word3, derived_lead_iii;
	int          exp_q[$];
	wire  [4:0]  mode_onehot;
	wire         word_valid, mode_error, ch_diff_en, ch_ce_ref_en, cm_config_used;
	int          bad_count = 0, comparisons = 0, frames, good = 0, e1, e2, e3, x[3];
	logic [31:0] seed = 32'h2B6D2BDA, r;
	logic [2:0]  sel;
	logic        ok;
	always #50 core_clk = ~core_clk;
	ecg_lead_format_select ecg_lead_format_select_inst (.*);
	host_frame_sink host_frame_sink_inst (.core_clk, .srst, .word_valid, .word1, .word2, .frames,
		.derived_lead_iii);
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100000 bad_count++;
		close_out;
	end
	// every select and rate code, unsupported ones meant to be refused
	initial begin
		repeat (4) @(posedge core_clk);
		srst <= 0;
		for (int m = 0; m < 32; m++) begin
			@(posedge core_clk);
			{output_format_select, input_config_select, common_electrode_enable, data_rate} <= m[4:0];
			r = xs();
			ch1_sample <= r[13:0];
			ch2_sample <= r[27:14];
			e1 = int'(r[13:0]) - 8192;
			e2 = int'(r[27:14]) - 8192;
			r = xs();
			ch3_sample <= r[13:0];
			e3 = int'(r[13:0]) - 8192;
			sample_valid <= 1;
			sel = m[4:2];
			ok = sel == 2 || sel == 1 || sel == 4 || sel == 5 || sel == 0 && m[1:0] < 2;
			case (sel)
				2: x = '{e1, -e2, e3};
				0: x = '{e1 - e3, e2 - e3, e2 - e1};
				// ra wired to the common input, v1 on the third channel
				1: x = '{e1, e2, e3 - (e1 + e2) / 3};
				default: x = '{e1, e2, e3};
			endcase
			for (int k = 0; k < 3; k++) exp_q.push_back(ok ? x[k] : 0);
			good += ok;
			@(posedge core_clk);
			sample_valid <= 0;
			// valid stands for one cycle, words hold until new samples; both appear two edges after the sample edge
			@(posedge core_clk);
			#1;
			chk(word_valid, ok);
			chk(word1, exp_q.pop_front());
			chk(word2, exp_q.pop_front());
			chk(word3, exp_q.pop_front());
			if (ok && sel[0]) chk(derived_lead_iii, e2 - e1);
			chk(mode_onehot, !ok ? 0 : sel == 2 ? 1 : sel == 0 ? 2 : sel == 1 ? 4 : sel == 4 ? 8 : 16);
			chk(mode_error, !ok);
			chk(cm_config_used, ok && sel != 0);
			chk(ch_diff_en, sel[1]);
			chk(ch_ce_ref_en, sel[0] && !sel[1]);
			$display("test %0d done", m);
		end
		@(posedge core_clk);
		#1 chk(frames[15:0], good[15:0]);
		close_out;
	end
endmodule // test_ecg_lead_format_select
`default_nettype wire
